// ---- sdd_core.sv ----
// Top of the sigma-delta decimator; comparator pin is asynchronous.
`timescale 1ns/1ps
module sdd_core
  import sdd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = SAMPLE_CYCLES,
  parameter int unsigned LEAD        = LEAD_CYCLES,
  parameter int unsigned DECIM       = DECIM_FACTOR
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Analog loop pins
  input  wire logic        cmp_in,
  output logic             fb_out,
  // Result stream
  output logic             res_valid,
  input  wire logic        res_ready,
  output sdd_pkg::sdd_result_s res_data,
  output logic             blk_strobe,
  output logic             overrun
);

  // ==========================================================
  // Pin synchroniser
  // ==========================================================
  logic cmp_s1_r, cmp_s2_r;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
    end
    else
    begin
      cmp_s1_r <= cmp_in;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  // ==========================================================
  // Sample tick timer
  // ==========================================================
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [TICK_W-1:0] LEAD_AT   = TICK_W'(LEAD);
  localparam logic [CNT_W:0]    DEC_LAST  = (CNT_W+1)'(DECIM - 1);

  logic [TICK_W-1:0] sample_tick_timer_r, sample_tick_timer_nxt;
  logic              tick;
  logic              drive_pt;

  // Free-running so every period is identical, no jitter from reload logic
  assign tick     = (sample_tick_timer_r == TICK_LAST);
  assign drive_pt = (sample_tick_timer_r == LEAD_AT - TICK_W'(1));

  always_comb
  begin
    sample_tick_timer_nxt = tick ? '0 : sample_tick_timer_r + TICK_W'(1);
  end

  // ==========================================================
  // Modulator and boxcar filter
  // ==========================================================
  sdd_phase_e       phase_r, phase_nxt;
  logic             bit_r, bit_nxt;
  logic             fb_r, fb_nxt;
  logic [CNT_W:0]   cnt_r, cnt_nxt;
  logic [ACC_W-1:0] acc_r, acc_nxt;
  sdd_result_s      push_data_r, push_data_nxt;
  logic             push_r, push_nxt;
  logic             strobe_r, strobe_nxt;
  logic             ovr_r, ovr_nxt;
  logic             buf_ready;

  always_comb
  begin
    phase_nxt     = phase_r;
    bit_nxt       = bit_r;
    fb_nxt        = fb_r;
    cnt_nxt       = cnt_r;
    acc_nxt       = acc_r;
    push_data_nxt = push_data_r;
    push_nxt      = 1'b0;
    strobe_nxt    = 1'b0;
    // Judged when the word is offered, so a pop in the tick cycle is no overrun
    ovr_nxt       = ovr_r | (push_r & ~buf_ready);
    unique case (phase_r)
      SDD_WAIT_SAMPLE:
      begin
        if (tick)
        begin
          bit_nxt   = cmp_s2_r;
          phase_nxt = SDD_WAIT_DRIVE;
          // Boxcar: add this sample, dump after the last one
          if (cnt_r == DEC_LAST)
          begin
            push_data_nxt.value = acc_r + ACC_W'(cmp_s2_r);
            push_nxt            = 1'b1;
            strobe_nxt          = 1'b1;
            acc_nxt             = '0;
            cnt_nxt             = '0;
          end
          else
          begin
            acc_nxt = acc_r + ACC_W'(cmp_s2_r);
            cnt_nxt = cnt_r + (CNT_W+1)'(1);
          end
        end
      end
      SDD_WAIT_DRIVE:
      begin
        if (drive_pt)
        begin
          fb_nxt    = ~bit_r;
          phase_nxt = SDD_WAIT_SAMPLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sample_tick_timer_r <= '0;
      phase_r             <= SDD_WAIT_SAMPLE;
      bit_r               <= 1'b0;
      fb_r                <= 1'b0;
      cnt_r               <= '0;
      acc_r               <= '0;
      push_data_r         <= '0;
      push_r              <= 1'b0;
      strobe_r            <= 1'b0;
      ovr_r               <= 1'b0;
    end
    else
    begin
      sample_tick_timer_r <= sample_tick_timer_nxt;
      phase_r             <= phase_nxt;
      bit_r               <= bit_nxt;
      fb_r                <= fb_nxt;
      cnt_r               <= cnt_nxt;
      acc_r               <= acc_nxt;
      push_data_r         <= push_data_nxt;
      push_r              <= push_nxt;
      strobe_r            <= strobe_nxt;
      ovr_r               <= ovr_nxt;
    end
  end

  // ==========================================================
  // Result buffer
  // ==========================================================
  // Buffer drain outputs are its own flip-flops; a full buffer drops the block
  sdd_skid u_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push_r),
    .in_ready  (buf_ready),
    .in_data   (push_data_r),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  assign fb_out     = fb_r;
  assign blk_strobe = strobe_r;
  assign overrun    = ovr_r;

  // ==========================================================
  // Checks
  // ==========================================================
  initial
  begin
    a_osr_floor: assert (OSR >= MIN_OSR_8BIT && DECIM_FACTOR <= OSR)
      else $error("oversampling too low");
  end

  a_lead_time: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(fb_r) |-> sample_tick_timer_r == LEAD_AT)
    else $error("feedback switched away from the lead point");

  a_fb_inverse: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(phase_r == SDD_WAIT_SAMPLE) |-> fb_r == ~bit_r)
    else $error("feedback not inverse of sample");

  a_fb_only_drive: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(fb_r) |-> $past(drive_pt) && $past(phase_r) == SDD_WAIT_DRIVE)
    else $error("feedback moved off drive point");

  a_tick_period: assert property (@(posedge clk) disable iff (sys_rst)
    tick |=> !tick [*5])
    else $error("tick too early");

  a_strobe_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    strobe_r |=> !strobe_r)
    else $error("strobe longer than one cycle");

  a_dump_clear: assert property (@(posedge clk) disable iff (sys_rst)
    strobe_r |-> acc_r == '0 && cnt_r == '0)
    else $error("sum not cleared after block");

  a_count_bound: assert property (@(posedge clk) disable iff (sys_rst)
    cnt_r <= DEC_LAST && acc_r <= ACC_W'(cnt_r))
    else $error("accumulator out of bounds");

  a_result_value: assert property (@(posedge clk) disable iff (sys_rst)
    strobe_r |-> push_data_r.value == $past(acc_r) + ACC_W'($past(cmp_s2_r)))
    else $error("result not the raw count");

endmodule

// ---- sdd_integ_model.sv ----
// Behavioural analog integrator with a threshold output, far side of the loop.
// Assumes fb_out of the decimator and a free-running system clock.
`timescale 1ns/1ps
module sdd_integ_model
#(
  parameter int VIN = 1,
  parameter int FS  = 2,
  parameter int LIM = 20
)
(
  // Clock
  input  wire logic clk,
  // Loop pins
  input  wire logic fb_out,
  output logic      cmp_out
);
  // ==========================================================
  // Integrator
  // ==========================================================
  // No reset: a real integrator keeps its charge across a reset
  // Output saturates at the rails, so a long one-sided run recovers quickly
  int acc = 0;
  int sum;

  always @(posedge clk)
  begin
    sum = acc + VIN - ((fb_out === 1'b1) ? FS : 0);
    acc <= (sum > LIM) ? LIM : ((sum < -LIM) ? -LIM : sum);
  end

  // Inverting stage, so a high feedback level pulls the sum down
  assign cmp_out = (acc < 0);
endmodule

// ---- sdd_pkg.sv ----
// Constants and carrier types for the sigma-delta decimator.
// Assumes a 125 MHz system clock.
package sdd_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_PERIOD_PS   = 8000;
  localparam int unsigned SAMPLE_PERIOD_NS = 3260;
  localparam int unsigned SAMPLE_CYCLES   = (SAMPLE_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned LEAD_NS         = 140;
  localparam int unsigned LEAD_CYCLES     = (LEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================
  // Decimation
  // ==========================================================
  localparam int unsigned DECIM_FACTOR = 256;
  localparam int unsigned OSR          = 512;
  localparam int unsigned MIN_OSR_8BIT = 64;
  localparam int unsigned ACC_W        = 9;
  localparam int unsigned TICK_W       = 10;
  localparam int unsigned CNT_W        = 8;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic [ACC_W-1:0] value;
  } sdd_result_s;

  typedef enum logic [0:0] {
    SDD_WAIT_SAMPLE = 1'b0,
    SDD_WAIT_DRIVE  = 1'b1
  } sdd_phase_e;

endpackage

// ---- sdd_skid.sv ----
// Two-entry buffer with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
module sdd_skid
  import sdd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Fill side
  input  wire logic        in_valid,
  output logic             in_ready,
  input  sdd_pkg::sdd_result_s in_data,
  // Drain side
  output logic             out_valid,
  input  wire logic        out_ready,
  output sdd_pkg::sdd_result_s out_data
);

  // ==========================================================
  // Storage
  // ==========================================================
  sdd_result_s  mem_r [2];
  sdd_result_s  mem_nxt [2];
  logic [1:0]   cnt_r, cnt_nxt;
  logic         rd_r, rd_nxt;
  logic         wr_r, wr_nxt;
  logic         vld_r, vld_nxt;
  sdd_result_s  head_r, head_nxt;
  logic         push, pop;

  assign push      = in_valid && (cnt_r != 2'd2);
  assign pop       = out_ready && (cnt_r != 2'd0);
  assign in_ready  = (cnt_r != 2'd2);
  // Drain side comes straight from flip-flops, copies of count and head
  assign out_valid = vld_r;
  assign out_data  = head_r;

  always_comb
  begin
    mem_nxt = mem_r;
    cnt_nxt = cnt_r;
    rd_nxt  = rd_r;
    wr_nxt  = wr_r;
    if (push)
    begin
      mem_nxt[wr_r] = in_data;
      wr_nxt        = ~wr_r;
    end
    if (pop)
      rd_nxt = ~rd_r;
    if (push && !pop)
      cnt_nxt = cnt_r + 2'd1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 2'd1;
    vld_nxt  = (cnt_nxt != 2'd0);
    head_nxt = mem_nxt[rd_nxt];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      cnt_r    <= 2'd0;
      rd_r     <= 1'b0;
      wr_r     <= 1'b0;
      vld_r    <= 1'b0;
      head_r   <= '0;
    end
    else
    begin
      mem_r  <= mem_nxt;
      cnt_r  <= cnt_nxt;
      rd_r   <= rd_nxt;
      wr_r   <= wr_nxt;
      vld_r  <= vld_nxt;
      head_r <= head_nxt;
    end
  end

endmodule

// ---- tb_top.sv ----
// Self-checking bench for the sigma-delta decimator.
// Assumes short simulation counts: 20-cycle tick, lead 3, block of 4.
`timescale 1ns/1ps
module tb_top;
  import sdd_pkg::*;

  typedef struct packed {
    logic [3:0] pat;
    logic [8:0] cnt;
  } sdd_row_s;

  // ==========================================================
  // Signals
  // ==========================================================
  localparam sdd_row_s ROWS [5] = '{'{4'h0, 9'h000}, '{4'hf, 9'h004}, '{4'ha, 9'h002},
                                   '{4'h1, 9'h001}, '{4'h7, 9'h003}};
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        tb_cmp = 1'b0;
  logic        use_model = 1'b0;
  logic        res_ready = 1'b0;
  logic        m_cmp;
  logic        fb_out;
  logic        res_valid;
  logic        blk_strobe;
  logic        overrun;
  sdd_result_s res_data;
  logic [3:0]  cur = 4'h0;
  logic [3:0]  nxt = 4'h0;
  logic        fo;
  int          failures = 0;
  int          tests_run = 0;
  int          n = 1000;

  sdd_core #(.TICK_CYCLES(20), .LEAD(3), .DECIM(4)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .cmp_in(use_model ? m_cmp : tb_cmp), .fb_out(fb_out), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data), .blk_strobe(blk_strobe), .overrun(overrun));
  sdd_integ_model i_far (.clk(clk), .fb_out(fb_out), .cmp_out(m_cmp));

  initial
  begin
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic blk();
    int i;
    for (i = 0; i < 200 && blk_strobe !== 1'b1; i++) @(negedge clk);
    if (i == 200) chk(9'h0, 9'h1);
    @(negedge clk);
  endtask

  task automatic pop(input logic [8:0] lo, input logic [8:0] hi);
    chk({8'h0, res_valid}, 9'h1);
    chk({8'h0, res_data.value >= lo && res_data.value <= hi}, 9'h1);
    res_ready = 1'b1;
    @(negedge clk);
    res_ready = 1'b0;
    // Idle edge, so back-to-back pops never re-raise ready in one step
    @(negedge clk);
  endtask

  task automatic final_report();
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Comparator stimulus and feedback timing, relative to strobe
  // ==========================================================
  always @(negedge clk)
  begin
    // A reset restarts the block count, so the spacing check skips one strobe
    if (sys_rst === 1'b1)
      n = 1000;
    else if (blk_strobe === 1'b1)
    begin
      if (n < 200) chk({8'h0, n == 79}, 9'h1);
      n = 0;
      cur = nxt;
    end
    else
      n = n + 1;
    if (n == 1) chk({8'h0, blk_strobe}, 9'h0);
    if (!use_model && n < 80 && n % 20 == 5)
    begin
      tb_cmp = cur[n / 20];
      fo = fb_out;
    end
    // Feedback holds until the lead runs out, then shows the inverse
    if (!use_model && n > 20 && n < 80 && n % 20 == 2) chk({8'h0, fb_out}, {8'h0, fo});
    if (!use_model && n > 20 && n < 80 && n % 20 == 3)
      chk({8'h0, fb_out}, {8'h0, ~cur[(n - 23) / 20]});
  end

  // Whole run is near 1000 cycles
  initial
  begin
    #200000;
    failures++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    repeat (8) @(negedge clk);
    chk({6'h0, fb_out, res_valid, overrun}, 9'h0);
    sys_rst = 1'b0;
    blk();
    pop(9'h000, 9'h000);
    for (int r = 0; r < 5; r++)
    begin
      nxt = ROWS[r].pat;
      blk();
      pop(ROWS[(r > 0) ? r - 1 : 0].cnt, ROWS[(r > 0) ? r - 1 : 0].cnt);
    end
    // Stall the sink until a full buffer drops a block
    nxt = 4'hf;
    blk();
    pop(ROWS[4].cnt, ROWS[4].cnt);
    nxt = 4'h1;
    blk();
    nxt = 4'h0;
    blk();
    chk({8'h0, overrun}, 9'h0);
    blk();
    @(negedge clk);
    chk({8'h0, overrun}, 9'h1);
    pop(9'h004, 9'h004);
    pop(9'h001, 9'h001);
    chk({8'h0, res_valid}, 9'h0);
    // Reset in mid-run, then close the loop through the integrator
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    chk({5'h0, fb_out, res_valid, overrun, blk_strobe}, 9'h0);
    use_model = 1'b1;
    sys_rst = 1'b0;
    blk();
    pop(9'h000, 9'h004);
    blk();
    pop(9'h001, 9'h003);
    final_report();
  end
endmodule
